//--- fan_loop_regs.svh
`ifndef FAN_LOOP_REGS_SVH
`define FAN_LOOP_REGS_SVH

// register indices; byte address is four times the index
`define IDX_R1_TARGET 7'h33
`define IDX_LOC_TARGET 7'h34
`define IDX_R2_TARGET 7'h35
`define IDX_CTL_FIRST 7'h36
`define IDX_CTL_SECOND 7'h37
`define IDX_R1_LOW 7'h4e
`define IDX_R1_HIGH 7'h4f
`define IDX_LOC_LOW 7'h50
`define IDX_LOC_HIGH 7'h51
`define IDX_R2_LOW 7'h52
`define IDX_R2_HIGH 7'h53
`define IDX_R1_FAN_START 7'h67
`define IDX_LOC_FAN_START 7'h68
`define IDX_R2_FAN_START 7'h69
`define IDX_LOOP_CONFIG 7'h6a
`define IDX_LOOP_STATUS 7'h6b

// reset values
`define RST_TARGET 8'ha4
`define RST_LOW 8'h01
`define RST_HIGH 8'h7f
`define RST_CTL 8'h00
`define RST_FAN_START 8'h5a

// field positions in the first loop control register
`define POS_ENABLE 5
`define POS_CAPTURE 2
`define POS_R2_CODE_HI 0
// field positions in the second loop control register
`define POS_R1_CODE 0
`define POS_LOC_CODE 3
`define POS_R2_CODE_LO 6
// field positions in own registers
`define POS_OFS64 0
`define POS_BELOW 0
`define POS_ABOVE 3

// timing: shortest short period, in monitoring cycles
`define SHORT_BASE 12'd8
// floors in ordered code form (two's complement -127, offset-64 -64)
`define FLOOR_TWOS 8'h01
`define FLOOR_OFS64 8'h00
// rise threshold in quarter degrees (0.25 degree)
`define RISE_SMALL 11'sd1

`endif

//--- fan_loop_pkg.sv
package fan_loop_pkg;

    // temperature with two fraction bits, 0.25 degree per lsb
    typedef logic [9:0] temp_q_t;

    typedef struct packed {
        temp_q_t remote2;
        temp_q_t local_ch;
        temp_q_t remote1;
    } temp_set_t;

    typedef struct packed {
        logic [3:0] remote2;
        logic [3:0] local_ch;
        logic [3:0] remote1;
    } hyst_set_t;

    typedef struct packed {
        logic [7:0] remote2;
        logic [7:0] local_ch;
        logic [7:0] remote1;
    } byte_set_t;

    typedef struct packed {
        logic [2:0] below_low;
        logic [2:0] above_high;
    } limit_event_t;

endpackage

//--- dynamic_fan_threshold_loop.sv
// Chosen here: the Avalon-MM register port.
`timescale 1ns/100ps
`include "fan_loop_regs.svh"

module dynamic_fan_threshold_loop
    import fan_loop_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [8:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    input wire logic mon_tick_i,
    input wire temp_set_t temp_i,
    input wire hyst_set_t hyst_i,
    input wire logic thermal_event_pin_n_i,
    output byte_set_t fan_start_o,
    output byte_set_t target_zone_temp_o,
    output limit_event_t limit_event_o
);

    logic [1:0] rst_sync_q;
    logic rst_n;

    logic [7:0] target_q [3];
    logic [7:0] low_q [3];
    logic [7:0] high_q [3];
    logic [7:0] tmin_q [3];
    logic [7:0] ctl1_q;
    logic [7:0] ctl2_q;
    logic ofs64_q;
    logic [11:0] cnt_q [3];
    temp_q_t prev_mon_q [3];
    temp_q_t prev_short_q [3];
    logic [2:0] below_q;
    logic [2:0] above_q;
    logic ack_q;
    logic [31:0] rdata_q;
    limit_event_t event_q;

    temp_q_t temp [3];
    logic [3:0] hyst [3];
    logic [2:0] code [3];
    logic [2:0] short_ev;
    logic [2:0] long_ev;
    logic [11:0] cnt_d [3];
    logic [7:0] tmin_d [3];
    logic [2:0] below_d;
    logic [2:0] above_d;
    logic [6:0] idx;
    logic wr_take;
    logic [7:0] wbyte;

    // maps a code to an order that unsigned compare gets right
    function automatic logic [7:0] ord8(input logic [7:0] v, input logic ofs);
        return ofs ? v : {~v[7], v[6:0]};
    endfunction

    function automatic logic [11:0] period(input logic [2:0] c);
        return `SHORT_BASE << c;
    endfunction

    function automatic logic signed [10:0] widen(input logic [7:0] v);
        return $signed({3'b000, v});
    endfunction

    function automatic logic [7:0] adjust(
        input temp_q_t t,
        input temp_q_t pm,
        input temp_q_t ps,
        input logic [7:0] tg,
        input logic [7:0] lo,
        input logic [7:0] hi,
        input logic [7:0] fs,
        input logic [3:0] hy,
        input logic ofs,
        input logic sh,
        input logic lg
    );
        logic signed [10:0] ot;
        logic signed [10:0] otg;
        logic signed [10:0] ol;
        logic signed [10:0] oh;
        logic signed [10:0] om;
        logic signed [10:0] oth;
        logic signed [10:0] rise_m;
        logic signed [10:0] rise_s;
        logic signed [10:0] res;
        logic signed [10:0] flo;
        logic [7:0] r8;
        ot = widen(ord8(t[9:2], ofs));
        otg = widen(ord8(tg, ofs));
        ol = widen(ord8(lo, ofs));
        oh = widen(ord8(hi, ofs));
        om = widen(ord8(fs, ofs));
        oth = otg - $signed({7'b0000000, hy});
        rise_m = $signed({1'b0, ord8(t[9:2], ofs), t[1:0]})
            - $signed({1'b0, ord8(pm[9:2], ofs), pm[1:0]});
        rise_s = $signed({1'b0, ord8(t[9:2], ofs), t[1:0]})
            - $signed({1'b0, ord8(ps[9:2], ofs), ps[1:0]});
        flo = widen(ofs ? `FLOOR_OFS64 : `FLOOR_TWOS);
        res = om;
        // below fan-start the loop rests; fan is off or at minimum
        if (ot < om)
        begin
            return fs;
        end
        // quarter-degree rise halved equals twice the rise in degrees
        if (sh && ot > oth && rise_s > `RISE_SMALL && rise_m > 11'sd0)
        begin
            res = res - (rise_m >>> 1);
        end
        if (lg)
        begin
            if (ot > otg)
            begin
                res = res - 11'sd1;
            end
            else if (ot < ol && ot > om && om < oh && om < otg)
            begin
                res = res + 11'sd1;
            end
        end
        if (res < flo)
        begin
            res = flo;
        end
        if (res > oh)
        begin
            res = oh;
        end
        r8 = res[7:0];
        return ord8(r8, ofs);
    endfunction

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rst_sync_q <= 2'b00;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    assign temp[0] = temp_i.remote1;
    assign temp[1] = temp_i.local_ch;
    assign temp[2] = temp_i.remote2;
    assign hyst[0] = hyst_i.remote1;
    assign hyst[1] = hyst_i.local_ch;
    assign hyst[2] = hyst_i.remote2;
    assign code[0] = ctl2_q[`POS_R1_CODE +: 3];
    assign code[1] = ctl2_q[`POS_LOC_CODE +: 3];
    assign code[2] = {ctl1_q[`POS_R2_CODE_HI], ctl2_q[`POS_R2_CODE_LO +: 2]};

    assign idx = address_i[8:2];
    assign wr_take = write_i && ack_q && byteenable_i[0];
    assign wbyte = writedata_i[7:0];
    // one wait state: the registered read data is ready on the second cycle
    assign waitrequest_o = (read_i || write_i) && !ack_q;

    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            cnt_d[i] = cnt_q[i] + 12'd1;
            short_ev[i] = mon_tick_i
                && ((cnt_d[i] & (period(code[i]) - 12'd1)) == 12'd0);
            long_ev[i] = mon_tick_i && (cnt_d[i] >= (period(code[i]) << 1));
            tmin_d[i] = adjust(temp[i], prev_mon_q[i], prev_short_q[i],
                target_q[i], low_q[i], high_q[i], tmin_q[i], hyst[i],
                ofs64_q, short_ev[i], long_ev[i]);
            below_d[i] = ord8(temp[i][9:2], ofs64_q) < ord8(low_q[i], ofs64_q);
            above_d[i] = ord8(temp[i][9:2], ofs64_q) > ord8(high_q[i], ofs64_q);
        end
    end

    // cycle counters, running on monitoring ticks only
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 3; i++)
            begin
                cnt_q[i] <= 12'd0;
                prev_mon_q[i] <= '0;
                prev_short_q[i] <= '0;
            end
        end
        else if (mon_tick_i)
        begin
            for (int i = 0; i < 3; i++)
            begin
                cnt_q[i] <= long_ev[i] ? 12'd0 : cnt_d[i];
                prev_mon_q[i] <= temp[i];
                if (short_ev[i])
                begin
                    prev_short_q[i] <= temp[i];
                end
            end
        end
    end

    // targets: software writes, thermal event capture overrides
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 3; i++)
            begin
                target_q[i] <= `RST_TARGET;
            end
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (!thermal_event_pin_n_i && ctl1_q[`POS_CAPTURE + i])
                begin
                    target_q[i] <= temp[i][9:2];
                end
                else if (wr_take && idx == `IDX_R1_TARGET + 7'(i))
                begin
                    target_q[i] <= wbyte;
                end
            end
        end
    end

    // limits and control
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 3; i++)
            begin
                low_q[i] <= `RST_LOW;
                high_q[i] <= `RST_HIGH;
            end
            ctl1_q <= `RST_CTL;
            ctl2_q <= `RST_CTL;
            ofs64_q <= 1'b0;
        end
        else if (wr_take)
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (idx == `IDX_R1_LOW + 7'(2 * i))
                begin
                    low_q[i] <= wbyte;
                end
                if (idx == `IDX_R1_HIGH + 7'(2 * i))
                begin
                    high_q[i] <= wbyte;
                end
            end
            if (idx == `IDX_CTL_FIRST)
            begin
                ctl1_q <= wbyte;
            end
            if (idx == `IDX_CTL_SECOND)
            begin
                ctl2_q <= wbyte;
            end
            if (idx == `IDX_LOOP_CONFIG)
            begin
                ofs64_q <= wbyte[`POS_OFS64];
            end
        end
    end

    // fan-start values; a software write takes precedence over the loop
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 3; i++)
            begin
                tmin_q[i] <= `RST_FAN_START;
            end
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (wr_take && idx == `IDX_R1_FAN_START + 7'(i))
                begin
                    tmin_q[i] <= wbyte;
                end
                else if (ctl1_q[`POS_ENABLE + i] && mon_tick_i)
                begin
                    tmin_q[i] <= tmin_d[i];
                end
            end
        end
    end

    // limit crossings, compared once per monitoring cycle
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            below_q <= 3'b000;
            above_q <= 3'b000;
            event_q <= '0;
        end
        else
        begin
            event_q <= '0;
            if (mon_tick_i)
            begin
                below_q <= below_d;
                above_q <= above_d;
                event_q.below_low <= below_d & ~below_q;
                event_q.above_high <= above_d & ~above_q;
            end
        end
    end

    // bus answer; unmapped addresses read zero and ignore writes
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= (read_i || write_i) && !ack_q;
            if (read_i && !ack_q)
            begin
                rdata_q <= 32'h0000_0000;
                case (idx)
                    `IDX_R1_TARGET: rdata_q[7:0] <= target_q[0];
                    `IDX_LOC_TARGET: rdata_q[7:0] <= target_q[1];
                    `IDX_R2_TARGET: rdata_q[7:0] <= target_q[2];
                    `IDX_CTL_FIRST: rdata_q[7:0] <= ctl1_q;
                    `IDX_CTL_SECOND: rdata_q[7:0] <= ctl2_q;
                    `IDX_R1_LOW: rdata_q[7:0] <= low_q[0];
                    `IDX_R1_HIGH: rdata_q[7:0] <= high_q[0];
                    `IDX_LOC_LOW: rdata_q[7:0] <= low_q[1];
                    `IDX_LOC_HIGH: rdata_q[7:0] <= high_q[1];
                    `IDX_R2_LOW: rdata_q[7:0] <= low_q[2];
                    `IDX_R2_HIGH: rdata_q[7:0] <= high_q[2];
                    `IDX_R1_FAN_START: rdata_q[7:0] <= tmin_q[0];
                    `IDX_LOC_FAN_START: rdata_q[7:0] <= tmin_q[1];
                    `IDX_R2_FAN_START: rdata_q[7:0] <= tmin_q[2];
                    `IDX_LOOP_CONFIG: rdata_q[`POS_OFS64] <= ofs64_q;
                    `IDX_LOOP_STATUS:
                    begin
                        rdata_q[`POS_BELOW +: 3] <= below_q;
                        rdata_q[`POS_ABOVE +: 3] <= above_q;
                    end
                    default: rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign readdata_o = rdata_q;
    assign limit_event_o = event_q;
    assign fan_start_o = '{remote2: tmin_q[2], local_ch: tmin_q[1],
        remote1: tmin_q[0]};
    assign target_zone_temp_o = '{remote2: target_q[2],
        local_ch: target_q[1], remote1: target_q[0]};

endmodule

//--- fan_loop_checker.sv
`timescale 1ns/100ps
module fan_loop_checker
    import fan_loop_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] readdata_o,
    input wire logic waitrequest_o,
    input wire logic mon_tick_i,
    input wire logic thermal_event_pin_n_i,
    input wire byte_set_t fan_start_o,
    input wire byte_set_t target_zone_temp_o,
    input wire limit_event_t limit_event_o
);
    logic rq;
    assign rq = read_i | write_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    a_first_wait: assert property ($rose(rq) |-> waitrequest_o)
        else $error("no wait state on new request");
    a_one_wait: assert property (rq && waitrequest_o |=> !waitrequest_o)
        else $error("more than one wait state");
    a_idle_free: assert property (!rq |-> !waitrequest_o)
        else $error("waitrequest without request");
    a_rd_upper: assert property (readdata_o[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_rd_stands: assert property
        (!$stable(readdata_o) |-> $past(read_i && waitrequest_o))
        else $error("read data moved without a read");
    a_ev_once: assert property (|limit_event_o |=>
        (limit_event_o & $past(limit_event_o)) == 6'h0)
        else $error("limit event longer than a cycle");
    a_ev_tick: assert property (|limit_event_o |-> $past(mon_tick_i))
        else $error("limit event without tick");
    a_fs_cause: assert property (!$stable(fan_start_o) |->
        $past(mon_tick_i) || $past(write_i && !waitrequest_o))
        else $error("fan start moved off a tick");
    a_tg_cause: assert property (!$stable(target_zone_temp_o) |->
        $past(!thermal_event_pin_n_i) || $past(write_i && !waitrequest_o))
        else $error("target moved without cause");
    cover property (|limit_event_o.below_low);
    cover property (|limit_event_o.above_high);
    cover property (!$stable(target_zone_temp_o));
endmodule

bind dynamic_fan_threshold_loop fan_loop_checker chk (.clk_i, .nrst_i,
    .read_i, .write_i, .readdata_o, .waitrequest_o, .mon_tick_i,
    .thermal_event_pin_n_i, .fan_start_o, .target_zone_temp_o,
    .limit_event_o);

//--- tb.sv
`timescale 1ns/100ps
`include "fan_loop_regs.svh"
module tb;
    import fan_loop_pkg::*;
    logic clk_i, nrst_i, read_i, write_i, waitrequest_o, mon_tick_i;
    logic thermal_event_pin_n_i;
    logic [8:0] address_i;
    logic [31:0] writedata_i, readdata_o;
    logic [3:0] byteenable_i;
    temp_set_t temp_i;
    hyst_set_t hyst_i;
    byte_set_t fan_start_o, target_zone_temp_o;
    limit_event_t limit_event_o;
    int error_cnt = 0;
    int cmp_count = 0;
    logic [2:0] seen_lo, seen_hi;
    logic clr_seen;
    logic [23:0] per [3] = '{24'd16, 24'd64, 24'd512};

    dynamic_fan_threshold_loop dut (.clk_i, .nrst_i, .address_i, .read_i,
        .write_i, .writedata_i, .byteenable_i, .readdata_o, .waitrequest_o,
        .mon_tick_i, .temp_i, .hyst_i, .thermal_event_pin_n_i, .fan_start_o,
        .target_zone_temp_o, .limit_event_o);

    initial
    begin
        clk_i = 0;
        forever #10 clk_i = ~clk_i;
    end

    // sticky so a one-cycle pulse is not missed between checks
    always @(posedge clk_i)
    begin
        seen_lo <= clr_seen ? 3'h0 : seen_lo | limit_event_o.below_low;
        seen_hi <= clr_seen ? 3'h0 : seen_hi | limit_event_o.above_high;
    end

    task clear_seen;
        @(posedge clk_i);
        clr_seen <= 1'b1;
        @(posedge clk_i);
        clr_seen <= 1'b0;
    endtask

    task conclude;
        if (error_cnt == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task chk(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // request held until waitrequest is seen low at a rising edge
    task bus(input logic wr, input logic [6:0] i, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge clk_i);
        address_i <= {i, 2'b00};
        writedata_i <= {24'h0, d};
        read_i <= !wr;
        write_i <= wr;
        @(posedge clk_i);
        while (waitrequest_o)
        begin
            @(posedge clk_i);
        end
        q = readdata_o[7:0];
        read_i <= 1'b0;
        write_i <= 1'b0;
    endtask

    task wr(input logic [6:0] i, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, i, d, q);
    endtask

    task rdc(input logic [6:0] i, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, i, 8'h00, q);
        chk(q, e);
    endtask

    task tick(input int n);
        repeat (n)
        begin
            @(posedge clk_i);
            mon_tick_i <= 1'b1;
            @(posedge clk_i);
            mon_tick_i <= 1'b0;
        end
    endtask

    function logic [7:0] fs(input int c);
        if (c == 0)
            return fan_start_o.remote1;
        if (c == 1)
            return fan_start_o.local_ch;
        return fan_start_o.remote2;
    endfunction

    // ticks until the channel's fan start moves; n ticks, d the change
    task step(input int c, output logic [23:0] n, output logic [7:0] d);
        logic [7:0] v;
        @(negedge clk_i);
        v = fs(c);
        n = 0;
        while (fs(c) === v && n < 1100)
        begin
            tick(1);
            @(negedge clk_i);
            n++;
        end
        d = fs(c) - v;
    endtask

    task setup(input logic [7:0] tg, lo, hi, f);
        for (logic [6:0] c = 0; c < 3; c++)
        begin
            wr(`IDX_R1_TARGET + c, tg);
            wr(`IDX_R1_LOW + (c << 1), lo);
            wr(`IDX_R1_HIGH + (c << 1), hi);
            wr(`IDX_R1_FAN_START + c, f);
        end
    endtask

    task hold(input logic [7:0] ctl, input temp_q_t t);
        byte_set_t v;
        wr(`IDX_CTL_FIRST, ctl);
        @(posedge clk_i);
        temp_i <= {t, t, t};
        @(negedge clk_i);
        v = fan_start_o;
        tick(40);
        @(negedge clk_i);
        chk(fan_start_o, v);
    endtask

    task t_reset;
        for (logic [6:0] c = 0; c < 3; c++)
        begin
            rdc(`IDX_R1_TARGET + c, 8'ha4);
            rdc(`IDX_R1_LOW + (c << 1), 8'h01);
            rdc(`IDX_R1_HIGH + (c << 1), 8'h7f);
        end
        rdc(7'h40, 8'h00);
    endtask

    // steady temperature above target: only the long cycle lowers
    task t_period;
        logic [23:0] n;
        logic [7:0] d;
        setup(8'h28, 8'h01, 8'h7f, 8'h1e);
        wr(`IDX_CTL_SECOND, 8'h50);
        wr(`IDX_CTL_FIRST, 8'he1);
        for (int c = 0; c < 3; c++)
        begin
            step(c, n, d);
            step(c, n, d);
            chk(n, per[c]);
            chk(d, 8'hff);
        end
    endtask

    // target above temperature so the long cycle may only raise
    task t_raise;
        logic [23:0] n;
        logic [7:0] d;
        clear_seen;
        setup(8'h40, 8'h3c, 8'h7f, 8'h1e);
        wr(`IDX_CTL_FIRST, 8'h20);
        step(0, n, d);
        step(0, n, d);
        chk(n, 24'd16);
        chk(d, 8'h01);
        chk(seen_lo, 3'h7);
    endtask

    // one degree per tick; eight ticks hold exactly one short cycle
    task t_short;
        wr(`IDX_CTL_FIRST, 8'h00);
        @(posedge clk_i);
        temp_i <= {3{10'd200}};
        hyst_i <= {3{4'hf}};
        tick(2);
        setup(8'h40, 8'h01, 8'h7f, 8'h14);
        wr(`IDX_CTL_FIRST, 8'h20);
        for (int k = 1; k <= 8; k++)
        begin
            @(posedge clk_i);
            temp_i <= {3{10'(200 + 4 * k)}};
            tick(1);
        end
        @(negedge clk_i);
        chk(fs(0), 8'h12);
    endtask

    // temperature settles while disabled so no rise is seen on enable
    task t_clamp;
        wr(`IDX_CTL_FIRST, 8'h00);
        @(posedge clk_i);
        temp_i <= {3{10'd480}};
        tick(2);
        clear_seen;
        setup(8'h28, 8'h01, 8'h30, 8'h40);
        wr(`IDX_CTL_FIRST, 8'h20);
        tick(1);
        rdc(`IDX_LOOP_STATUS, 8'h38);
        @(negedge clk_i);
        chk(fs(0), 8'h30);
        chk(seen_hi, 3'h7);
    endtask

    task t_capture;
        wr(`IDX_CTL_FIRST, 8'h08);
        @(posedge clk_i);
        thermal_event_pin_n_i <= 1'b0;
        @(posedge clk_i);
        thermal_event_pin_n_i <= 1'b1;
        @(negedge clk_i);
        chk(target_zone_temp_o, 24'h287828);
    endtask

    // fan-start at the floor stays there while the long cycle lowers
    task t_floor;
        for (int m = 0; m < 2; m++)
        begin
            wr(`IDX_LOOP_CONFIG, 8'(m));
            rdc(`IDX_LOOP_CONFIG, 8'(m));
            setup(8'h28, 8'h01, 8'h7f, m ? 8'h00 : 8'h81);
            wr(`IDX_CTL_FIRST, 8'h20);
            tick(20);
            @(negedge clk_i);
            chk(fs(0), m ? 8'h00 : 8'h81);
        end
    endtask

    initial
    begin
        repeat (60000) @(posedge clk_i);
        error_cnt++;
        conclude;
    end

    initial
    begin
        nrst_i = 1'b0;
        read_i = 1'b0;
        write_i = 1'b0;
        address_i = 9'h0;
        writedata_i = 32'h0;
        byteenable_i = 4'hf;
        mon_tick_i = 1'b0;
        thermal_event_pin_n_i = 1'b1;
        temp_i = {3{10'd200}};
        hyst_i = {3{4'h2}};
        clr_seen = 1'b1;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        clr_seen <= 1'b0;
        repeat (3) @(posedge clk_i);
        t_reset;
        t_period;
        setup(8'h28, 8'h01, 8'h7f, 8'h14);
        hold(8'he0, 10'd140);
        hold(8'h00, 10'd200);
        t_raise;
        setup(8'h28, 8'h0f, 8'h7f, 8'h14);
        hold(8'he0, 10'd40);
        t_short;
        t_clamp;
        t_capture;
        t_floor;
        conclude;
    end
endmodule
